//--- rtl/rru_addr_former.v
/*
 * Operand address former for memory rotates: pointer pair or base plus
 * absolute low byte, extended by the page register in the large models.
 * Assumes a purely combinational use; the caller latches the address.
 */
`timescale 1ns/10ps
`include "rru_defs.vh"

module rru_addr_former (
  input wire [1:0] opnd,
  input wire [7:0] ptr_high,
  input wire [7:0] ptr_low,
  input wire [7:0] base_upper_byte_reg,
  input wire [7:0] abs_low,
  input wire [7:0] expand_page_reg,
  input wire large_memory_models,
  output wire [23:0] addr
);

  wire [7:0] page;
  wire [15:0] logical;

  // small models see a single page
  assign page = large_memory_models ? expand_page_reg : `RRU_RST_PAGE;
  assign logical = (opnd == `RRU_OPND_BASE) ?
                   {base_upper_byte_reg, abs_low} :
                   {ptr_high, ptr_low};
  assign addr = {page, logical};

endmodule

//--- rtl/rru_defs.vh
/*
 * Constants of the rotate unit: register offsets, command fields, flag bit
 * positions, operand selectors and instruction cycle counts.
 * Assumes it is included by bare name from each design file.
 */
`ifndef RRU_DEFS_VH
`define RRU_DEFS_VH

`define RRU_OFS_ACC_A 4'h0
`define RRU_OFS_ACC_B 4'h1
`define RRU_OFS_PTR_LOW 4'h2
`define RRU_OFS_PTR_HIGH 4'h3
`define RRU_OFS_BASE 4'h4
`define RRU_OFS_PAGE 4'h5
`define RRU_OFS_FLAGS 4'h6
`define RRU_OFS_MODEL 4'h7
`define RRU_OFS_CMD 4'h8
`define RRU_OFS_ABS 4'h9
`define RRU_OFS_STATUS 4'ha

`define RRU_OP_RL 2'h0
`define RRU_OP_RLC 2'h1
`define RRU_OP_RR 2'h2
`define RRU_OP_RRC 2'h3

`define RRU_OPND_A 2'h0
`define RRU_OPND_B 2'h1
`define RRU_OPND_PTR 2'h2
`define RRU_OPND_BASE 2'h3

`define RRU_FLAG_Z 0
`define RRU_FLAG_C 1
`define RRU_FLAG_N 3

`define RRU_STAT_BUSY 0
`define RRU_STAT_DONE 1

`define RRU_RST_BYTE 8'h00
`define RRU_RST_PAGE 8'h00
`define RRU_RST_CNT 4'h0
`define RRU_CNT_ONE 4'h1
`define RRU_CLK_PER_CYC 4'h2
`define RRU_CYC_REG 4'h3
`define RRU_CYC_PTR 4'h4
`define RRU_CYC_BASE 4'h5

`endif

//--- rtl/rru_rotate_unit.v
/*
 * Rotate datapath of an 8-bit core: accumulators, pointer pair, base and
 * page registers, condition flags and the sequencer that runs one rotate
 * per command, on a register or by read-modify-write on data memory.
 * Assumes one clock, a register port answering one cycle after a read
 * strobe, and a data memory on the same clock that returns read data in
 * the cycle after its read strobe and takes a write in the strobe cycle.
 */
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "rru_defs.vh"

module rru_rotate_unit (
  input wire clk,
  input wire rst,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg [23:0] mem_addr,
  output reg mem_rd,
  output reg mem_wr,
  output reg [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  output reg busy
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_READ = 5'h02;
  localparam [4:0] ST_CAPTURE = 5'h04;
  localparam [4:0] ST_PAD = 5'h08;
  localparam [4:0] ST_STORE = 5'h10;

  reg [4:0] state;
  reg [4:0] next_state;
  reg [3:0] cnt;
  reg [3:0] total;
  reg [7:0] acc_a;
  reg [7:0] acc_b;
  reg [7:0] ptr_low;
  reg [7:0] ptr_high;
  reg [7:0] base_upper_byte_reg;
  reg [7:0] expand_page_reg;
  reg [7:0] system_condition_flags;
  reg large_memory_models;
  reg [1:0] cmd_op;
  reg [1:0] cmd_opnd;
  reg [7:0] abs_low;
  reg [7:0] operand;
  reg done;

  wire start;
  wire wr_ok;
  wire to_store;
  wire [23:0] formed_addr;
  wire [7:0] rot_result;
  wire rot_carry;
  wire rot_neg;
  wire rot_zero;

  // memory operand selectors decode to a read-modify-write
  function is_mem;
    input [1:0] opnd;
    begin
      is_mem = (opnd == `RRU_OPND_PTR) || (opnd == `RRU_OPND_BASE);
    end
  endfunction

  // clocks the whole instruction occupies, two per instruction cycle
  function [3:0] clocks_for;
    input [1:0] opnd;
    begin
      case (opnd)
        `RRU_OPND_PTR: begin
          clocks_for = `RRU_CYC_PTR * `RRU_CLK_PER_CYC;
        end
        `RRU_OPND_BASE: begin
          clocks_for = `RRU_CYC_BASE * `RRU_CLK_PER_CYC;
        end
        default: begin
          clocks_for = `RRU_CYC_REG * `RRU_CLK_PER_CYC;
        end
      endcase
    end
  endfunction

  assign start = reg_wr && (reg_addr == `RRU_OFS_CMD) && !busy;
  // state that feeds an instruction is frozen while it runs
  assign wr_ok = reg_wr && !busy;
  assign to_store = (state == ST_PAD) && (cnt == total - `RRU_CNT_ONE);

  rru_addr_former u_addr (
    .opnd(reg_wdata[3:2]),
    .ptr_high(ptr_high),
    .ptr_low(ptr_low),
    .base_upper_byte_reg(base_upper_byte_reg),
    .abs_low(abs_low),
    .expand_page_reg(expand_page_reg),
    .large_memory_models(large_memory_models),
    .addr(formed_addr)
  );

  rru_rotator u_rot (
    .op(cmd_op),
    .din(operand),
    .cin(system_condition_flags[`RRU_FLAG_C]),
    .dout(rot_result),
    .cout(rot_carry),
    .neg(rot_neg),
    .zero(rot_zero)
  );

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = is_mem(reg_wdata[3:2]) ? ST_READ : ST_PAD;
        end
      end
      ST_READ: begin
        next_state = ST_CAPTURE;
      end
      ST_CAPTURE: begin
        next_state = ST_PAD;
      end
      ST_PAD: begin
        if (to_store) begin
          next_state = ST_STORE;
        end
      end
      ST_STORE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt <= `RRU_RST_CNT;
      total <= `RRU_RST_CNT;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      if (start) begin
        cnt <= `RRU_CNT_ONE;
        total <= clocks_for(reg_wdata[3:2]);
        busy <= 1'b1;
      end else if (state == ST_STORE) begin
        cnt <= `RRU_RST_CNT;
        busy <= 1'b0;
      end else if (busy) begin
        cnt <= cnt + `RRU_CNT_ONE;
      end
    end
  end

  // command latch and operand capture
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_op <= `RRU_OP_RL;
      cmd_opnd <= `RRU_OPND_A;
      operand <= `RRU_RST_BYTE;
    end else begin
      if (start) begin
        cmd_op <= reg_wdata[1:0];
        cmd_opnd <= reg_wdata[3:2];
        if (reg_wdata[3:2] == `RRU_OPND_B) begin
          operand <= acc_b;
        end else begin
          operand <= acc_a;
        end
      end else if (state == ST_CAPTURE) begin
        operand <= mem_rdata;
      end
    end
  end

  // data memory strobes; the address stays put from read to write-back
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_addr <= {`RRU_RST_PAGE, `RRU_RST_BYTE, `RRU_RST_BYTE};
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= `RRU_RST_BYTE;
    end else begin
      mem_rd <= start && is_mem(reg_wdata[3:2]);
      mem_wr <= to_store && is_mem(cmd_opnd);
      if (start && is_mem(reg_wdata[3:2])) begin
        mem_addr <= formed_addr;
      end
      if (to_store && is_mem(cmd_opnd)) begin
        mem_wdata <= rot_result;
      end
    end
  end

  // accumulators
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_a <= `RRU_RST_BYTE;
      acc_b <= `RRU_RST_BYTE;
    end else begin
      if (to_store && (cmd_opnd == `RRU_OPND_A)) begin
        acc_a <= rot_result;
      end else if (wr_ok && (reg_addr == `RRU_OFS_ACC_A)) begin
        acc_a <= reg_wdata;
      end
      if (to_store && (cmd_opnd == `RRU_OPND_B)) begin
        acc_b <= rot_result;
      end else if (wr_ok && (reg_addr == `RRU_OFS_ACC_B)) begin
        acc_b <= reg_wdata;
      end
    end
  end

  // address registers and memory model
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_low <= `RRU_RST_BYTE;
      ptr_high <= `RRU_RST_BYTE;
      base_upper_byte_reg <= `RRU_RST_BYTE;
      expand_page_reg <= `RRU_RST_PAGE;
      large_memory_models <= 1'b0;
      abs_low <= `RRU_RST_BYTE;
    end else if (wr_ok) begin
      case (reg_addr)
        `RRU_OFS_PTR_LOW: begin
          ptr_low <= reg_wdata;
        end
        `RRU_OFS_PTR_HIGH: begin
          ptr_high <= reg_wdata;
        end
        `RRU_OFS_BASE: begin
          base_upper_byte_reg <= reg_wdata;
        end
        `RRU_OFS_PAGE: begin
          expand_page_reg <= reg_wdata;
        end
        `RRU_OFS_MODEL: begin
          large_memory_models <= reg_wdata[0];
        end
        `RRU_OFS_ABS: begin
          abs_low <= reg_wdata;
        end
        default: begin
          abs_low <= abs_low;
        end
      endcase
    end
  end

  // condition flags: only negative, carry and zero move on a rotate
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      system_condition_flags <= `RRU_RST_BYTE;
    end else if (to_store) begin
      system_condition_flags[`RRU_FLAG_N] <= rot_neg;
      system_condition_flags[`RRU_FLAG_Z] <= rot_zero;
      system_condition_flags[`RRU_FLAG_C] <= rot_carry;
    end else if (wr_ok && (reg_addr == `RRU_OFS_FLAGS)) begin
      system_condition_flags <= reg_wdata;
    end
  end

  // completion flag: a finishing rotate beats a clear in the same cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else if (state == ST_STORE) begin
      done <= 1'b1;
    end else if (reg_wr && (reg_addr == `RRU_OFS_STATUS) &&
                 reg_wdata[`RRU_STAT_DONE]) begin
      done <= 1'b0;
    end else if (start) begin
      done <= 1'b0;
    end
  end

  // read data stand only in the cycle after the strobe
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `RRU_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `RRU_OFS_ACC_A: begin
          reg_rdata <= acc_a;
        end
        `RRU_OFS_ACC_B: begin
          reg_rdata <= acc_b;
        end
        `RRU_OFS_PTR_LOW: begin
          reg_rdata <= ptr_low;
        end
        `RRU_OFS_PTR_HIGH: begin
          reg_rdata <= ptr_high;
        end
        `RRU_OFS_BASE: begin
          reg_rdata <= base_upper_byte_reg;
        end
        `RRU_OFS_PAGE: begin
          reg_rdata <= expand_page_reg;
        end
        `RRU_OFS_FLAGS: begin
          reg_rdata <= system_condition_flags;
        end
        `RRU_OFS_MODEL: begin
          reg_rdata <= {7'h00, large_memory_models};
        end
        `RRU_OFS_CMD: begin
          reg_rdata <= {4'h0, cmd_opnd, cmd_op};
        end
        `RRU_OFS_ABS: begin
          reg_rdata <= abs_low;
        end
        `RRU_OFS_STATUS: begin
          reg_rdata <= {6'h00, done, busy};
        end
        default: begin
          reg_rdata <= `RRU_RST_BYTE;
        end
      endcase
    end else begin
      reg_rdata <= `RRU_RST_BYTE;
    end
  end

endmodule

//--- rtl/rru_rotator.v
/*
 * One-bit rotator: left or right, through carry or circular, with the
 * negative and zero results of the rotated byte.
 * Assumes a purely combinational use; the caller registers the results.
 */
`timescale 1ns/10ps
`include "rru_defs.vh"

module rru_rotator (
  input wire [1:0] op,
  input wire [7:0] din,
  input wire cin,
  output reg [7:0] dout,
  output reg cout,
  output wire neg,
  output wire zero
);

  always @* begin
    dout = din;
    cout = cin;
    case (op)
      `RRU_OP_RL: begin
        dout = {din[6:0], cin};
        cout = din[7];
      end
      `RRU_OP_RLC: begin
        dout = {din[6:0], din[7]};
        cout = din[7];
      end
      `RRU_OP_RR: begin
        dout = {cin, din[7:1]};
        cout = din[0];
      end
      default: begin
        dout = {din[0], din[7:1]};
        cout = din[0];
      end
    endcase
  end

  assign neg = dout[7];
  assign zero = (dout == `RRU_RST_BYTE);

endmodule

//--- verification/rru_mem_model.sv
/*
 * Data memory model on the far side of the rotate unit.
 * Assumes one clock; read data stand only in the cycle after a read strobe.
 */
`timescale 1ns/10ps
module rru_mem_model (
  input logic clk,
  input logic [23:0] mem_addr,
  input logic mem_rd,
  input logic mem_wr,
  input logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic [23:0] last_addr
);
  logic [7:0] mem [0:255];
  initial begin
    mem_rdata = 8'h00;
    last_addr = 24'h000000;
  end
  always @(posedge clk) begin
    // outside the answer cycle the data toggle, so a late capture is seen
    if (mem_rd)
      mem_rdata <= mem[mem_addr[7:0]];
    else
      mem_rdata <= ~mem_rdata;
    if (mem_wr) begin
      mem[mem_addr[7:0]] <= mem_wdata;
      last_addr <= mem_addr;
    end
  end
endmodule

//--- verification/rru_rotate_unit_chk.sv
/*
 * Timing checker of the rotate unit ports.
 * Assumes it is bound to rru_rotate_unit and sees only its ports.
 */
`timescale 1ns/10ps
module rru_chk (
  input logic clk,
  input logic rst,
  input logic [3:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic busy,
  input logic [23:0] mem_addr,
  input logic mem_rd,
  input logic mem_wr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] sh [0:15];
  logic [23:0] rd_a;
  wire cmd = reg_wr && reg_addr == 4'h8 && !busy;
  wire [1:0] od = reg_wdata[3:2];
  wire [7:0] pg = sh[7][0] ? sh[5] : 8'h00;
  wire [23:0] a_ptr = {pg, sh[3], sh[2]};
  wire [23:0] a_base = {pg, sh[4], sh[9]};
  // shadow of the registers, writes while busy are dropped
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++)
        sh[i] <= 8'h00;
      rd_a <= 24'h000000;
    end else begin
      if (reg_wr && !busy)
        sh[reg_addr] <= reg_wdata;
      if (mem_rd)
        rd_a <= mem_addr;
    end
  end
  property p_reg_len; cmd && !od[1] |=> busy [*6] ##1 !busy; endproperty
  a_reg_len: assert property (p_reg_len) else $error("register rotate length");
  property p_ptr_len; cmd && od == 2'h2 |=> busy [*8] ##1 !busy; endproperty
  a_ptr_len: assert property (p_ptr_len) else $error("pointer rotate length");
  property p_base_len; cmd && od == 2'h3 |=> busy [*8] ##1 busy [*2] ##1 !busy; endproperty
  a_base_len: assert property (p_base_len) else $error("base rotate length");
  property p_ptr_addr; cmd && od == 2'h2 |=> mem_rd && mem_addr == $past(a_ptr); endproperty
  a_ptr_addr: assert property (p_ptr_addr) else $error("pointer address");
  property p_base_addr; cmd && od == 2'h3 |=> mem_rd && mem_addr == $past(a_base); endproperty
  a_base_addr: assert property (p_base_addr) else $error("base address");
  property p_ptr_wr; cmd && od == 2'h2 |-> ##8 mem_wr; endproperty
  a_ptr_wr: assert property (p_ptr_wr) else $error("pointer write-back");
  property p_base_wr; cmd && od == 2'h3 |-> ##10 mem_wr; endproperty
  a_base_wr: assert property (p_base_wr) else $error("base write-back");
  property p_same; mem_wr |-> mem_addr == rd_a; endproperty
  a_same: assert property (p_same) else $error("write-back address moved");
  property p_wr_last; mem_wr |=> !mem_wr && !busy; endproperty
  a_wr_last: assert property (p_wr_last) else $error("write-back not last");
  c_reg: cover property (cmd && !od[1] ##7 !busy);
  c_ptr: cover property (cmd && od == 2'h2 ##8 mem_wr);
  c_base: cover property (cmd && od == 2'h3 ##10 mem_wr);
endmodule
bind rru_rotate_unit rru_chk i_chk (.*);

//--- verification/rru_rotate_unit_tb.sv
/*
 * Self-checking bench of the rotate unit with a data memory model.
 * Assumes the checker is bound to the design and one 40 MHz clock.
 */
`timescale 1ns/10ps
module rru_rotate_unit_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, mem_wdata, mem_rdata;
  logic [23:0] mem_addr, last_addr;
  logic mem_rd, mem_wr, busy;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  rru_rotate_unit i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .busy(busy));
  rru_mem_model i_mem (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .last_addr(last_addr));
  task automatic wrap_up;
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      wrap_up;
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  // command, then count the cycles that busy stands
  task automatic run(input logic [3:0] cmd, input int n);
    int cnt;
    cnt = 0;
    wr(4'h8, {4'h0, cmd});
    @(negedge clk);
    while (busy === 1'b1 && cnt < 40) begin
      cnt++;
      @(negedge clk);
    end
    chk(24'(cnt), 24'(n));
    rd(4'ha, 8'h02);
  endtask
  // flags start with V, D, U, I0, I1 set and N, Z opposite to the result
  task automatic t_reg(input logic [3:0] cmd, input logic [7:0] din, input logic c,
      input logic [7:0] dq, input logic [2:0] ncz);
    wr({2'b00, cmd[3:2]}, din);
    wr(4'h6, {4'hf, ~ncz[2], 1'b1, c, ~ncz[0]});
    run(cmd, 6);
    rd({2'b00, cmd[3:2]}, dq);
    rd(4'h6, {4'hf, ncz[2], 1'b1, ncz[1:0]});
  endtask
  task automatic t_mem(input logic [3:0] cmd, input logic [7:0] din, input logic c,
      input logic [7:0] dq, input logic [2:0] ncz, input int n, input logic [23:0] ea);
    i_mem.mem[ea[7:0]] = din;
    wr(4'h6, {4'hf, ~ncz[2], 1'b1, c, ~ncz[0]});
    run(cmd, n);
    chk(i_mem.mem[ea[7:0]], dq);
    chk(last_addr, ea);
    rd(4'h6, {4'hf, ncz[2], 1'b1, ncz[1:0]});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(4'h6, 8'h00);
    rd(4'hf, 8'h00);
    t_reg(4'h1, 8'he3, 1'b0, 8'hc7, 3'b110);
    t_reg(4'h5, 8'h3b, 1'b1, 8'h76, 3'b000);
    t_reg(4'h2, 8'h7e, 1'b0, 8'h3f, 3'b000);
    t_reg(4'h6, 8'hd4, 1'b1, 8'hea, 3'b100);
    t_reg(4'h2, 8'h01, 1'b0, 8'h00, 3'b011);
    t_reg(4'h0, 8'h4c, 1'b0, 8'h98, 3'b100);
    t_reg(4'h7, 8'hc6, 1'b1, 8'h63, 3'b000);
    wr(4'h2, 8'h34);
    wr(4'h3, 8'h12);
    wr(4'h4, 8'h56);
    wr(4'h9, 8'h78);
    wr(4'h5, 8'h9a);
    wr(4'h7, 8'h01);
    t_mem(4'h8, 8'h83, 1'b0, 8'h06, 3'b010, 8, 24'h9a1234);
    t_mem(4'h8, 8'ha2, 1'b1, 8'h45, 3'b010, 8, 24'h9a1234);
    t_mem(4'h9, 8'he3, 1'b0, 8'hc7, 3'b110, 8, 24'h9a1234);
    t_mem(4'hd, 8'h3b, 1'b1, 8'h76, 3'b000, 10, 24'h9a5678);
    t_mem(4'he, 8'hd4, 1'b1, 8'hea, 3'b100, 10, 24'h9a5678);
    t_mem(4'he, 8'h51, 1'b0, 8'h28, 3'b010, 10, 24'h9a5678);
    wr(4'h7, 8'h00);
    t_mem(4'h8, 8'h4c, 1'b0, 8'h98, 3'b100, 8, 24'h001234);
    t_mem(4'hc, 8'h4c, 1'b0, 8'h98, 3'b100, 10, 24'h005678);
    t_mem(4'hb, 8'hc6, 1'b1, 8'h63, 3'b000, 8, 24'h001234);
    t_mem(4'hf, 8'hd7, 1'b0, 8'heb, 3'b110, 10, 24'h005678);
    // completion flag clears on a write of one to its bit
    wr(4'ha, 8'h02);
    rd(4'ha, 8'h00);
    wrap_up;
  end
endmodule
